/* common/rcb_pkg.sv */
// Shared constants and types for the radio side-band and stream port
package rcb_pkg;
  localparam int unsigned SYS_HZ    = 100_000_000;
  localparam int unsigned STREAM_HZ = 1_000_000;
  localparam int unsigned WARN_NS   = 2000;
  localparam logic [5:0]  HALF_CYC  = 6'(SYS_HZ / (2 * STREAM_HZ));
  localparam logic [7:0]  WARN_CYC  = 8'((WARN_NS * (SYS_HZ / 1_000_000)) / 1000);
  localparam int          BYTE_W    = 8;
  localparam int          FIFO_W    = 9;
  localparam int          FIFO_D    = 8;
  localparam logic [3:0]  BYTE_BITS = 4'h8;
  localparam int          SYNC_W    = 3;
  localparam int          SYNC_INH  = 0;
  localparam int          SYNC_GNT  = 1;
  localparam int          SYNC_OSC  = 2;
  localparam int          MON_W     = 9;

  typedef enum logic [2:0] {
    EVT_IDLE = 3'h1,
    EVT_WARN = 3'h2,
    EVT_RUN  = 3'h4
  } rcb_evt_e;
endpackage

/* common/rcb_link_if.sv */
// Side-band and bit stream wires between the radio and its outside partners
`timescale 1ns/1ns
`default_nettype none
interface rcb_link_if;
  logic radio_event_active;
  logic stream_bit_clock;
  logic stream_bit_data;
  logic stream_frame_marker;
  logic radio_txrx_indicator;
  logic radio_high_priority_out;
  logic radio_pre_event_wake;
  logic fem_rx_select;
  logic fem_tx_select;
  logic external_osc_request_out;
  logic radio_inhibit_in;
  logic antenna_grant_in;
  logic internal_osc_request_in;

  modport dev (
    output radio_event_active, stream_bit_clock, stream_bit_data, stream_frame_marker,
    output radio_txrx_indicator, radio_high_priority_out, radio_pre_event_wake,
    output fem_rx_select, fem_tx_select, external_osc_request_out,
    input  radio_inhibit_in, antenna_grant_in, internal_osc_request_in
  );
  modport far (
    input  radio_event_active, stream_bit_clock, stream_bit_data, stream_frame_marker,
    input  radio_txrx_indicator, radio_high_priority_out, radio_pre_event_wake,
    input  fem_rx_select, fem_tx_select, external_osc_request_out,
    output radio_inhibit_in, antenna_grant_in, internal_osc_request_in
  );
endinterface
`default_nettype wire

/* hw/rcb_dev_end.sv */
// Radio end: event sequencer, side-band outputs, byte FIFO and bit stream serializer
`timescale 1ns/1ns
`default_nettype none
module rcb_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic        full;
    logic        empty;
  } rcb_fifo_s;

  logic [W-1:0] mem [D];
  rcb_fifo_s    st_ff;
  rcb_fifo_s    nxt_st;
  logic         push;
  logic         pop;
  assign push      = in_valid && !st_ff.full;
  assign pop       = out_ready && !st_ff.empty;
  assign in_ready  = !st_ff.full;
  assign out_valid = !st_ff.empty;
  assign out_data  = mem[st_ff.rptr[AW-1:0]];
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
      nxt_st.wptr = st_ff.wptr + 1'b1;
    if (pop)
      nxt_st.rptr = st_ff.rptr + 1'b1;
    nxt_st.empty = (nxt_st.wptr == nxt_st.rptr);
    nxt_st.full  = (nxt_st.wptr[AW-1:0] == nxt_st.rptr[AW-1:0]) &&
                   (nxt_st.wptr[AW] != nxt_st.rptr[AW]);
  end
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      st_ff <= '{wptr: '0, rptr: '0, full: 1'b0, empty: 1'b1};
    else
      st_ff <= nxt_st;

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge sys_clk)
    if (push)
      mem[st_ff.wptr[AW-1:0]] <= in_data;
endmodule

module rcb_dev_end (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Event control
  input  wire logic        evt_start,
  input  wire logic        evt_tx,
  input  wire logic        evt_high_prio,
  input  wire logic        evt_stop,
  input  wire logic        sw_status_en,
  input  wire logic        sw_status_val,
  output logic             evt_busy,
  // Oscillators
  input  wire logic        need_ext_osc,
  input  wire logic        soc_on_rf_osc,
  output logic             radio_osc_turn_on_request,
  // Received bytes toward the stream
  input  wire logic        bit_stream_capture_mode,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_byte_last,
  input  wire logic        rx_byte_valid,
  output logic             rx_byte_ready,
  // Link
  rcb_link_if.dev          link
);
  typedef struct packed {
    rcb_pkg::rcb_evt_e               state;
    logic                            tx;
    logic [7:0]                      warn_cnt;
    logic [rcb_pkg::SYNC_W-1:0]      sync1;
    logic [rcb_pkg::SYNC_W-1:0]      sync2;
    logic                            busy;
    logic                            active;
    logic                            wake;
    logic                            prio;
    logic                            fem_rx;
    logic                            fem_tx;
    logic                            status;
    logic                            ext_osc;
    logic                            osc_on;
    logic [5:0]                      div;
    logic                            sclk;
    logic                            sdata;
    logic                            frame;
    logic [7:0]                      shift;
    logic [3:0]                      bits;
    logic                            last;
    logic                            in_rdy;
    logic [3:0]                      fill;
  } rcb_dev_s;

  rcb_dev_s                    st_ff;
  rcb_dev_s                    nxt_st;
  logic [rcb_pkg::FIFO_W-1:0]  fifo_out;
  logic                        fifo_valid;
  logic                        fifo_pop;
  logic                        fifo_push;
  logic                        fall_tick;
  logic                        inhibit;
  logic                        grant;
  assign inhibit   = st_ff.sync2[rcb_pkg::SYNC_INH];
  assign grant     = st_ff.sync2[rcb_pkg::SYNC_GNT];
  assign fall_tick = bit_stream_capture_mode && st_ff.sclk &&
                     (st_ff.div == rcb_pkg::HALF_CYC - 6'h01);
  // Hold the last byte's slot open for one bit so frames never merge
  assign fifo_pop  = fall_tick && (st_ff.bits == 4'h0) && !st_ff.last && fifo_valid;
  assign fifo_push = rx_byte_valid && st_ff.in_rdy;
  rcb_fifo #(
    .W (rcb_pkg::FIFO_W),
    .D (rcb_pkg::FIFO_D)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   ({rx_byte_last, rx_byte}),
    .in_valid  (fifo_push),
    .in_ready  (),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sync1 = {link.internal_osc_request_in, link.antenna_grant_in,
                    link.radio_inhibit_in};
    nxt_st.sync2 = st_ff.sync1;
    if (fifo_push != fifo_pop)
      nxt_st.fill = fifo_push ? st_ff.fill + 4'h1 : st_ff.fill - 4'h1;
    // Ready is registered, so it must already tell whether the next word fits
    nxt_st.in_rdy = (nxt_st.fill != 4'(rcb_pkg::FIFO_D));

    case (st_ff.state)
      rcb_pkg::EVT_IDLE:
      begin
        // Requests during inhibit are dropped, not queued
        if (evt_start && !inhibit)
        begin
          nxt_st.state    = rcb_pkg::EVT_WARN;
          nxt_st.tx       = evt_tx;
          nxt_st.prio     = evt_high_prio;
          nxt_st.warn_cnt = rcb_pkg::WARN_CYC - 8'h01;
        end
      end
      rcb_pkg::EVT_WARN:
        if (inhibit)
          nxt_st.state = rcb_pkg::EVT_IDLE;
        else if (st_ff.warn_cnt != 8'h00)
          nxt_st.warn_cnt = st_ff.warn_cnt - 8'h01;
        else if (!st_ff.tx || grant)
          nxt_st.state = rcb_pkg::EVT_RUN;
      rcb_pkg::EVT_RUN:
        if (inhibit || evt_stop)
          nxt_st.state = rcb_pkg::EVT_IDLE;
      default:
        nxt_st.state = rcb_pkg::EVT_IDLE;
    endcase
    nxt_st.busy   = (nxt_st.state != rcb_pkg::EVT_IDLE);
    nxt_st.active = nxt_st.busy;
    nxt_st.wake   = (nxt_st.state == rcb_pkg::EVT_WARN);
    if (nxt_st.state == rcb_pkg::EVT_IDLE)
      nxt_st.prio = 1'b0;
    nxt_st.fem_rx = (nxt_st.state == rcb_pkg::EVT_RUN) && !nxt_st.tx;
    nxt_st.fem_tx = (nxt_st.state == rcb_pkg::EVT_RUN) && nxt_st.tx;
    nxt_st.status = sw_status_en ? sw_status_val :
                    (nxt_st.state == rcb_pkg::EVT_RUN);
    nxt_st.osc_on  = st_ff.sync2[rcb_pkg::SYNC_OSC];
    nxt_st.ext_osc = need_ext_osc || soc_on_rf_osc || nxt_st.busy;
    if (!bit_stream_capture_mode)
    begin
      // Partial byte is abandoned when the mode drops
      nxt_st.div   = 6'h00;
      nxt_st.sclk  = 1'b0;
      nxt_st.frame = 1'b0;
      nxt_st.sdata = 1'b0;
      nxt_st.bits  = 4'h0;
      nxt_st.last  = 1'b0;
    end
    else
    begin
      if (st_ff.div == rcb_pkg::HALF_CYC - 6'h01)
      begin
        nxt_st.div  = 6'h00;
        nxt_st.sclk = !st_ff.sclk;
      end
      else
        nxt_st.div = st_ff.div + 6'h01;
      if (fall_tick)
      begin
        if (st_ff.bits != 4'h0)
        begin
          nxt_st.sdata = st_ff.shift[0];
          nxt_st.shift = {1'b0, st_ff.shift[7:1]};
          nxt_st.bits  = st_ff.bits - 4'h1;
        end
        else if (fifo_pop)
        begin
          nxt_st.sdata = fifo_out[0];
          nxt_st.shift = {1'b0, fifo_out[7:1]};
          nxt_st.bits  = rcb_pkg::BYTE_BITS - 4'h1;
          nxt_st.last  = fifo_out[rcb_pkg::BYTE_W];
          nxt_st.frame = 1'b1;
        end
        else
        begin
          nxt_st.sdata = 1'b0;
          nxt_st.frame = 1'b0;
          nxt_st.last  = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff       <= '0;
      st_ff.state <= rcb_pkg::EVT_IDLE;
    end
    else
      st_ff <= nxt_st;
  end
  assign evt_busy                      = st_ff.busy;
  assign radio_osc_turn_on_request     = st_ff.osc_on;
  assign rx_byte_ready                 = st_ff.in_rdy;
  assign link.radio_event_active       = st_ff.active;
  assign link.radio_pre_event_wake     = st_ff.wake;
  assign link.radio_high_priority_out  = st_ff.prio;
  assign link.radio_txrx_indicator     = st_ff.status;
  assign link.fem_rx_select            = st_ff.fem_rx;
  assign link.fem_tx_select            = st_ff.fem_tx;
  assign link.external_osc_request_out = st_ff.ext_osc;
  assign link.stream_bit_clock         = st_ff.sclk;
  assign link.stream_bit_data          = st_ff.sdata;
  assign link.stream_frame_marker      = st_ff.frame;
endmodule
`default_nettype wire

/* hw/rcb_far_end.sv */
// Partner end: coexistence inputs to the radio, side-band monitor and stream capture
`timescale 1ns/1ns
`default_nettype none
module rcb_far_end (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Drives toward the radio
  input  wire logic        inhibit_req,
  input  wire logic        antenna_free,
  input  wire logic        osc_req,
  // Monitored side-band levels
  output logic [8:0]       mon_levels,
  // Captured stream bytes
  output logic [7:0]       cap_byte,
  output logic             cap_first,
  output logic             cap_valid,
  // Link
  rcb_link_if.far          link
);
  typedef struct packed {
    logic [rcb_pkg::MON_W-1:0] mon1;
    logic [rcb_pkg::MON_W-1:0] mon2;
    logic                      tg1;
    logic                      tg2;
    logic                      tg_seen;
    logic [7:0]                byte_q;
    logic                      first_q;
    logic                      valid_q;
    logic                      inh;
    logic                      gnt;
    logic                      osc;
  } rcb_far_sys_s;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] cnt;
    logic       prev_frame;
    logic       first;
    logic [7:0] hold;
    logic       hold_first;
    logic       tg;
  } rcb_far_lnk_s;

  rcb_far_sys_s s_ff;
  rcb_far_sys_s nxt_s;
  rcb_far_lnk_s l_ff;
  rcb_far_lnk_s nxt_l;

  // Link domain: sample on the rising stream clock edge
  always_comb
  begin
    nxt_l = l_ff;
    nxt_l.prev_frame = link.stream_frame_marker;
    if (!link.stream_frame_marker)
    begin
      nxt_l.cnt = 3'h0;
    end
    else
    begin
      if (!l_ff.prev_frame)
        nxt_l.first = 1'b1;
      nxt_l.shift = {link.stream_bit_data, l_ff.shift[7:1]};
      nxt_l.cnt   = l_ff.cnt + 3'h1;
      if (l_ff.cnt == 3'h7)
      begin
        nxt_l.hold       = nxt_l.shift;
        nxt_l.hold_first = nxt_l.first;
        nxt_l.first      = 1'b0;
        nxt_l.tg         = !l_ff.tg;
      end
    end
  end

  always_ff @(posedge link.stream_bit_clock or posedge rst)
  begin
    if (rst)
      l_ff <= '0;
    else
      l_ff <= nxt_l;
  end

  // System domain; held word is stable for a full byte time after the toggle
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.mon1 = {link.stream_frame_marker, link.external_osc_request_out,
                  link.fem_tx_select, link.fem_rx_select, link.radio_pre_event_wake,
                  link.radio_high_priority_out, link.radio_txrx_indicator,
                  link.radio_event_active, link.stream_bit_clock};
    nxt_s.mon2    = s_ff.mon1;
    nxt_s.tg1     = l_ff.tg;
    nxt_s.tg2     = s_ff.tg1;
    nxt_s.valid_q = 1'b0;
    if (s_ff.tg2 != s_ff.tg_seen)
    begin
      nxt_s.tg_seen = s_ff.tg2;
      nxt_s.byte_q  = l_ff.hold;
      nxt_s.first_q = l_ff.hold_first;
      nxt_s.valid_q = 1'b1;
    end
    nxt_s.inh = inhibit_req;
    nxt_s.gnt = antenna_free;
    nxt_s.osc = osc_req;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign mon_levels                   = s_ff.mon2;
  assign cap_byte                     = s_ff.byte_q;
  assign cap_first                    = s_ff.first_q;
  assign cap_valid                    = s_ff.valid_q;
  assign link.radio_inhibit_in        = s_ff.inh;
  assign link.antenna_grant_in        = s_ff.gnt;
  assign link.internal_osc_request_in = s_ff.osc;
endmodule
`default_nettype wire

/* test/rcb_link_sva.sv */
// Concurrent checks on the side-band and stream wires between the two ends
`timescale 1ns/1ns
`default_nettype none
module rcb_link_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Event side-band
  input wire logic radio_event_active,
  input wire logic radio_high_priority_out,
  input wire logic radio_pre_event_wake,
  input wire logic fem_rx_select,
  input wire logic fem_tx_select,
  input wire logic external_osc_request_out,
  // Stream
  input wire logic stream_bit_clock,
  input wire logic stream_bit_data,
  input wire logic stream_frame_marker,
  // Far end drives
  input wire logic radio_inhibit_in,
  input wire logic antenna_grant_in
);
  localparam logic [7:0] HALF = {2'b00, rcb_pkg::HALF_CYC};
  // Run lengths; the low and wake counts saturate so a stopped clock never wraps back into range
  logic [7:0] hi_cnt_ff;
  logic [7:0] lo_cnt_ff;
  logic [7:0] wk_cnt_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hi_cnt_ff <= 8'h00;
      lo_cnt_ff <= 8'h00;
      wk_cnt_ff <= 8'h00;
    end
    else
    begin
      hi_cnt_ff <= stream_bit_clock ? hi_cnt_ff + 8'h01 : 8'h00;
      lo_cnt_ff <= stream_bit_clock ? 8'h00 : lo_cnt_ff + {7'h00, lo_cnt_ff != 8'hFF};
      wk_cnt_ff <= radio_pre_event_wake ? wk_cnt_ff + {7'h00, wk_cnt_ff != 8'hFF} : 8'h00;
    end
  end

  AST_FEM_EXCL: assert property (!(fem_rx_select && fem_tx_select))
    else $error("both front end selects high");
  AST_ACTIVE_RUN: assert property ((fem_rx_select || fem_tx_select) |-> radio_event_active)
    else $error("front end select without event active");
  AST_WAKE_FIRST: assert property ($rose(fem_rx_select || fem_tx_select)
    |-> $fell(radio_pre_event_wake) && $past(radio_event_active))
    else $error("run began without wake phase");
  AST_WAKE_LEN: assert property ($fell(radio_pre_event_wake) && fem_rx_select
    |-> wk_cnt_ff == rcb_pkg::WARN_CYC)
    else $error("wake phase length wrong");
  AST_PRIO_IDLE: assert property (!radio_event_active |-> !radio_high_priority_out)
    else $error("priority high outside event");
  AST_EXT_OSC: assert property (radio_event_active |-> external_osc_request_out)
    else $error("no oscillator request during event");
  AST_INHIBIT: assert property (radio_inhibit_in [*8] |-> !radio_event_active)
    else $error("event still active under inhibit");
  AST_TX_GRANT: assert property ($rose(fem_tx_select) |-> $past(antenna_grant_in, 2))
    else $error("transmit began without grant");
  AST_DATA_EDGE: assert property (($changed(stream_bit_data) || $changed(stream_frame_marker))
    |-> !stream_bit_clock)
    else $error("stream data changed while clock high");
  AST_CLK_HIGH: assert property ($fell(stream_bit_clock) && stream_frame_marker
    |-> hi_cnt_ff == HALF)
    else $error("stream clock high phase wrong");
  AST_CLK_LOW: assert property ($rose(stream_bit_clock) && stream_frame_marker
    |-> lo_cnt_ff == HALF)
    else $error("stream clock low phase wrong");
  AST_FRAME_IDLE: assert property (lo_cnt_ff > HALF
    |-> !stream_frame_marker && !stream_bit_data)
    else $error("frame or data high with clock stopped");
endmodule
`default_nettype wire

/* test/radio_coex_bitstream_port_test.sv */
// Bench joining both ends: events, oscillators, inhibit and byte stream
`timescale 1ns/1ns
`default_nettype none
module radio_coex_bitstream_port_test;
  logic       sys_clk, rst, evt_start, evt_tx, evt_high_prio, evt_stop, evt_busy;
  logic       sw_status_en, sw_status_val, need_ext_osc, soc_on_rf_osc, radio_osc_turn_on_request;
  logic       bit_stream_capture_mode, rx_byte_last, rx_byte_valid, rx_byte_ready;
  logic       inhibit_req, antenna_free, osc_req, cap_first, cap_valid, prev_frame;
  logic [7:0] rx_byte, cap_byte, sh;
  logic [8:0] mon_levels;
  logic [8:0] exp_q[$];
  logic [7:0] wire_q[$];
  int         n_errors, total_checks, seed, nb, len;

  rcb_link_if rcb_link_if_i ();
  rcb_dev_end rcb_dev_end_i (.*, .link(rcb_link_if_i.dev));
  rcb_far_end rcb_far_end_i (.*, .link(rcb_link_if_i.far));
  rcb_link_sva rcb_link_sva_i (.sys_clk(sys_clk), .rst(rst),
    .radio_event_active(rcb_link_if_i.radio_event_active),
    .radio_high_priority_out(rcb_link_if_i.radio_high_priority_out),
    .radio_pre_event_wake(rcb_link_if_i.radio_pre_event_wake),
    .fem_rx_select(rcb_link_if_i.fem_rx_select), .fem_tx_select(rcb_link_if_i.fem_tx_select),
    .external_osc_request_out(rcb_link_if_i.external_osc_request_out),
    .stream_bit_clock(rcb_link_if_i.stream_bit_clock),
    .stream_bit_data(rcb_link_if_i.stream_bit_data),
    .stream_frame_marker(rcb_link_if_i.stream_frame_marker),
    .radio_inhibit_in(rcb_link_if_i.radio_inhibit_in),
    .antenna_grant_in(rcb_link_if_i.antenna_grant_in));

  // Same bit order as the far end monitor, so one expectation serves both
  wire [8:0] lv = {rcb_link_if_i.stream_frame_marker, rcb_link_if_i.external_osc_request_out,
    rcb_link_if_i.fem_tx_select, rcb_link_if_i.fem_rx_select, rcb_link_if_i.radio_pre_event_wake,
    rcb_link_if_i.radio_high_priority_out, rcb_link_if_i.radio_txrx_indicator,
    rcb_link_if_i.radio_event_active, rcb_link_if_i.stream_bit_clock};

  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Holds valid and data until a negedge shows ready, then lets the edge take it
  task automatic push(input logic [7:0] b, input logic first, input logic last);
    rx_byte = b;
    rx_byte_last = last;
    rx_byte_valid = 1'b1;
    while (rx_byte_ready !== 1'b1) tick(1);
    tick(1);
    exp_q.push_back({first, b});
    wire_q.push_back(b);
  endtask

  task automatic evt(input logic tx, input logic prio);
    logic [8:0] run;
    run = {2'b01, tx, !tx, 1'b0, prio, 3'b110};
    evt_tx = tx;
    evt_high_prio = prio;
    evt_start = 1'b1;
    tick(1);
    evt_start = 1'b0;
    tick(1);
    chk("warn", lv, {5'b01001, prio, 3'b010});
    if (tx)
    begin
      tick(300);
      chk("grant wait", lv, {5'b01001, prio, 3'b010});
      antenna_free = 1'b1;
    end
    for (int i = 0; i < 400 && lv[6:5] == 2'b00; i++) tick(1);
    evt_start = 1'b1;
    evt_tx = !tx;
    tick(1);
    evt_start = 1'b0;
    tick(5);
    chk("run", lv, run);
    chk("monitor", mon_levels, run);
    sw_status_en = 1'b1;
    tick(3);
    chk("sw low", lv, run & 9'h1FB);
    sw_status_en = 1'b0;
    evt_stop = 1'b1;
    tick(1);
    evt_stop = 1'b0;
    tick(2);
    chk("stop", lv, 9'h000);
  endtask

  // Bits are taken at the rising stream edge, first bit into the low end
  always @(posedge rcb_link_if_i.stream_bit_clock)
  begin
    if (rcb_link_if_i.stream_frame_marker === 1'b1)
    begin
      if (prev_frame !== 1'b1) nb = 0;
      sh = {rcb_link_if_i.stream_bit_data, sh[7:1]};
      nb++;
      if (nb == 8) chk("wire", {1'b0, sh}, {1'b0, wire_q.size() ? wire_q.pop_front() : 8'hFF});
      if (nb == 8) nb = 0;
    end
    prev_frame = rcb_link_if_i.stream_frame_marker;
  end

  always @(negedge sys_clk)
    if (cap_valid === 1'b1) chk("capture", {cap_first, cap_byte}, exp_q.size() ? exp_q.pop_front() : 9'h1FF);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Generous span: event and stream phases together need about 15000 cycles
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end

  initial
  begin
    seed = 94;
    {rst, evt_start, evt_tx, evt_high_prio, evt_stop, sw_status_en, sw_status_val} = 7'h01 << 6;
    {need_ext_osc, soc_on_rf_osc, bit_stream_capture_mode, rx_byte_last, rx_byte_valid} = 5'h00;
    {inhibit_req, antenna_free, osc_req, prev_frame, rx_byte} = 12'h000;
    tick(1);
    chk("reset", {rx_byte_ready, lv[7:0]}, 9'h000);
    tick(1);
    rst = 1'b0;
    sw_status_en = 1'b1;
    sw_status_val = 1'b1;
    tick(3);
    chk("sw high", lv, 9'h004);
    sw_status_val = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {soc_on_rf_osc, need_ext_osc} = 2'(i);
      osc_req = i[0] ^ i[1];
      tick(8);
      chk("ext osc", lv, {1'b0, i[0] | i[1], 7'h00});
      chk("rf osc", {8'h00, radio_osc_turn_on_request}, {8'h00, osc_req});
    end
    {soc_on_rf_osc, need_ext_osc, osc_req, sw_status_en} = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      antenna_free = 1'b0;
      tick(5);
      evt(i[0], i[1] ^ 1'($random(seed)));
    end
    evt_start = 1'b1;
    tick(1);
    evt_start = 1'b0;
    tick(20);
    inhibit_req = 1'b1;
    tick(10);
    chk("inhibit", {evt_busy, lv[7:0]}, 9'h000);
    evt_start = 1'b1;
    tick(1);
    evt_start = 1'b0;
    tick(4);
    chk("inhibit start", {evt_busy, lv[7:0]}, 9'h000);
    inhibit_req = 1'b0;
    tick(5);
    // Stream held off so the buffer fills and refuses the ninth byte
    for (int i = 0; i < 11; i++)
    begin
      if (i == 8)
      begin
        tick(4);
        chk("fifo full", {8'h00, rx_byte_ready}, 9'h000);
        bit_stream_capture_mode = 1'b1;
      end
      push(8'($random(seed)), i == 0, i == 10);
    end
    len = 1 + int'($unsigned($random(seed)) % 5);
    for (int j = 0; j < len; j++) push(8'($random(seed)), j == 0, j == len - 1);
    rx_byte_valid = 1'b0;
    for (int i = 0; i < 30000 && exp_q.size() + wire_q.size() > 0; i++) tick(1);
    chk("drained", 9'(exp_q.size() + wire_q.size()), 9'h000);
    bit_stream_capture_mode = 1'b0;
    tick(200);
    chk("stream idle", lv, 9'h000);
    stop_test();
  end
endmodule
`default_nettype wire
